/* File: src/crtb_pkg.sv */
/*
 Constants for the clock, reset and timebase unit: register offsets,
 field positions, reset values and delay counts.
 Assumes a single 50 MHz system clock standing in for the internal clock.
*/
package crtb_pkg;
	// Register map
	localparam logic [7:0] CRTB_OSC_CTRL_OFFSET = 8'hDB;
	localparam logic [7:0] CRTB_RST_STATUS_OFFSET = 8'hDA;
	localparam logic [7:0] CRTB_OSC_CTRL_RESET = 8'h00;
	// Field positions in standby_osc_control
	localparam int CRTB_IRQ_EN_BIT = 7;
	localparam int CRTB_ELAPSED_BIT = 6;
	localparam int CRTB_OSC_RUN_BIT = 5;
	// Clock dividers
	localparam logic [3:0] CRTB_CORE_DIV = 4'hD;
	localparam logic [3:0] CRTB_CONV_DIV = 4'hC;
	localparam logic [3:0] CRTB_CHAIN_MAX = 4'hF;
	// Stabilisation delay in internal clock cycles
	localparam logic [11:0] CRTB_STAB_CYCLES = 12'h800;
	// Reset vector
	localparam logic [11:0] CRTB_RESET_VECTOR = 12'hFFE;
	// Reset cause codes
	typedef enum logic [1:0] {CAUSE_NONE, CAUSE_PIN, CAUSE_POR, CAUSE_WDOG} crtb_cause_t;
endpackage : crtb_pkg

/* File: src/crtb_clock_reset_timebase.sv */
/*
 Clock and reset unit: core and converter clock enables, the standby
 timebase with its control register, and reset merging with delay.
 Assumes synchronous inputs, a clean standby clock tick provided as a
 one-cycle enable, and a register port driven by the core.
*/
// Overview of operation
// - Core tick every 13 internal clocks, converter/watchdog tick every 12.
// - Running standby oscillator feeds display and chain; interrupt every chain wrap.
// - Stopped oscillator: chain fed by core tick, period 13 times 16.
// - Top control bit enables timebase interrupt; clear means no request.
// - Bit 6 flag set on each period expiry; request when flag and enable.
// - Bit 5 runs oscillator and selects it as chain source.
// - Any reset clears the whole oscillator control register.
// - Reset sources are pin, power-on detector and watchdog timeout.
// - Pin reset accepted in any mode; held while the pin is low.
// - Internal reset stretched by a delay, so short pin pulses reset fully.
// - Pin reset in run or wait halts code, inputs pulled up, oscillator restarts.
// - Pin reset in stop starts oscillator and pulls up inputs first.
// - Counter holds internal reset 2048 clocks after external release.
// - Power-on holds reset until oscillator runs, then stabilisation delay.
// - Watchdog end of count asserts internal reset, reinitialising watchdog.
// - Watchdog reset restarts as a pin reset, with full delay.
// - Reset pin has an internal pull-up.
// - Leaving reset empties stack and loads program counter with 0FFEh.
// - Core starts in non-maskable context until the first interrupt return.
module crtb_clock_reset_timebase
	import crtb_pkg::*;
(
	// Clock, reset, enable
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic clkEn,
	// Reset sources and oscillator status
	input wire logic resetPin_n,
	input wire logic porActive,
	input wire logic wdogTimeout,
	input wire logic mainOscReady,
	input wire logic stopMode,
	// Standby oscillator tick, one cycle per standby clock
	input wire logic standbyTick,
	// Core interrupt return
	input wire logic interruptReturnInstr,
	// Register port
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdData,
	// Clock enables out
	output logic coreTick,
	output logic convTick,
	output logic displayClkEn,
	output logic standbyOscRun,
	// Reset and core start
	output logic coreReset,
	output logic ioPullupAll,
	output logic mainOscRestart,
	output logic wdogReinit,
	output logic stackClear,
	output logic pcLoad,
	output logic [11:0] pcLoadValue,
	output logic nmiContext,
	output logic resetPinPullup,
	// Timebase interrupt
	output logic timebaseIrq
);

	typedef enum logic [1:0] {ST_HOLD, ST_WAIT_OSC, ST_DELAY, ST_RUN} crtb_rst_state_t;

	logic [3:0] coreDiv_r;
	logic [3:0] convDiv_r;
	logic [3:0] chain_r;
	logic [7:0] oscCtrl_r;
	logic [11:0] stabCount_r;
	logic [11:0] stabCount_nxt;
	crtb_rst_state_t rstState_r;
	crtb_rst_state_t rstState_nxt;
	crtb_cause_t cause_r;
	logic resetReq;
	logic chainAdvance;
	logic chainWrap;
	logic regWrCtrl;
	logic coreTickNow;
	logic leaveDelay;

	assign resetReq = !resetPin_n || porActive || wdogTimeout;

	assign coreTickNow = (coreDiv_r == CRTB_CORE_DIV - 4'h1);
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			coreDiv_r <= 4'h0;
		else if (clkEn)
			coreDiv_r <= coreTickNow ? 4'h0 : coreDiv_r + 4'h1;
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
			convDiv_r <= 4'h0;
		else if (clkEn)
			convDiv_r <= (convDiv_r == CRTB_CONV_DIV - 4'h1) ? 4'h0 : convDiv_r + 4'h1;
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
			coreTick <= 1'b0;
		else if (clkEn)
			coreTick <= coreTickNow;
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
			convTick <= 1'b0;
		else if (clkEn)
			convTick <= (convDiv_r == CRTB_CONV_DIV - 4'h1);
	end

	// Core tick feeds chain when stopped
	assign chainAdvance = oscCtrl_r[CRTB_OSC_RUN_BIT] ? standbyTick : coreTickNow;
	assign chainWrap = chainAdvance && (chain_r == CRTB_CHAIN_MAX);

	always_ff @(posedge clk_sys)
	begin
		if (srst)
			chain_r <= 4'h0;
		else if (clkEn && chainAdvance)
			chain_r <= chain_r + 4'h1;
	end

	assign regWrCtrl = regWrite && (regAddr == CRTB_OSC_CTRL_OFFSET);

	always_ff @(posedge clk_sys)
	begin
		if (srst)
			oscCtrl_r <= CRTB_OSC_CTRL_RESET;
		// Writes during internal reset are lost; frozen with clkEn low
		else if (clkEn && coreReset)
			oscCtrl_r <= CRTB_OSC_CTRL_RESET;
		else if (clkEn)
		begin
			if (regWrCtrl)
			begin
				oscCtrl_r[CRTB_IRQ_EN_BIT] <= regWrData[CRTB_IRQ_EN_BIT];
				oscCtrl_r[CRTB_OSC_RUN_BIT] <= regWrData[CRTB_OSC_RUN_BIT];
				oscCtrl_r[4:0] <= 5'h00;
			end
			// Flag set on wrap; set wins over clear
			if (chainWrap)
				oscCtrl_r[CRTB_ELAPSED_BIT] <= 1'b1;
			else if (regWrCtrl)
				oscCtrl_r[CRTB_ELAPSED_BIT] <= regWrData[CRTB_ELAPSED_BIT];
		end
	end

	// Standby clock to display while running
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			displayClkEn <= 1'b0;
		else if (clkEn)
			displayClkEn <= oscCtrl_r[CRTB_OSC_RUN_BIT] && standbyTick;
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
			standbyOscRun <= 1'b0;
		else if (clkEn)
			standbyOscRun <= oscCtrl_r[CRTB_OSC_RUN_BIT];
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
			timebaseIrq <= 1'b0;
		else if (clkEn)
			timebaseIrq <= oscCtrl_r[CRTB_IRQ_EN_BIT] && oscCtrl_r[CRTB_ELAPSED_BIT];
	end

	// Read data one cycle after the strobe; unmapped reads as zero
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			regRdData <= 8'h00;
		else if (clkEn)
		begin
			if (regRead && regAddr == CRTB_OSC_CTRL_OFFSET)
				regRdData <= oscCtrl_r;
			else if (regRead && regAddr == CRTB_RST_STATUS_OFFSET)
				regRdData <= {6'h00, cause_r};
			else
				regRdData <= 8'h00;
		end
	end

	// Held while any source is active
	always_comb
	begin
		rstState_nxt = rstState_r;
		stabCount_nxt = stabCount_r;
		case (rstState_r)
			ST_HOLD:
			begin
				stabCount_nxt = 12'h000;
				if (!resetReq)
					rstState_nxt = ST_WAIT_OSC;
			end
			ST_WAIT_OSC:
			begin
				stabCount_nxt = 12'h000;
				if (resetReq)
					rstState_nxt = ST_HOLD;
				else if (mainOscReady)
					rstState_nxt = ST_DELAY;
			end
			ST_DELAY:
			begin
				stabCount_nxt = stabCount_r + 12'h001;
				if (resetReq)
					rstState_nxt = ST_HOLD;
				else if (stabCount_r == CRTB_STAB_CYCLES - 12'h001)
					rstState_nxt = ST_RUN;
			end
			ST_RUN:
			begin
				// Any pulse restarts the full sequence
				if (resetReq)
					rstState_nxt = ST_HOLD;
			end
			default:
				rstState_nxt = ST_HOLD;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			rstState_r <= ST_HOLD;
			stabCount_r <= 12'h000;
		end
		else if (clkEn)
		begin
			rstState_r <= rstState_nxt;
			stabCount_r <= stabCount_nxt;
		end
	end

	// Last cause kept so software can tell a watchdog restart apart
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			cause_r <= CAUSE_POR;
		else if (clkEn)
		begin
			if (porActive)
				cause_r <= CAUSE_POR;
			else if (wdogTimeout)
				cause_r <= CAUSE_WDOG;
			else if (!resetPin_n)
				cause_r <= CAUSE_PIN;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
			coreReset <= 1'b1;
		else if (clkEn)
			coreReset <= (rstState_nxt != ST_RUN);
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
			ioPullupAll <= 1'b1;
		else if (clkEn)
			ioPullupAll <= (rstState_nxt != ST_RUN);
	end

	// Oscillator restart on a reset request from run or from stop
	// Latched at entry, so a long pin hold keeps the oscillator request up
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			mainOscRestart <= 1'b0;
		else if (clkEn)
			mainOscRestart <= resetReq && (rstState_r == ST_RUN || stopMode || mainOscRestart);
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
			wdogReinit <= 1'b1;
		else if (clkEn)
			wdogReinit <= (rstState_nxt != ST_RUN);
	end

	// Last delay cycle, the edge that starts the core
	assign leaveDelay = (rstState_r == ST_DELAY) && (rstState_nxt == ST_RUN);

	always_ff @(posedge clk_sys)
	begin
		if (srst)
			stackClear <= 1'b0;
		else if (clkEn)
			stackClear <= leaveDelay;
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
			pcLoad <= 1'b0;
		else if (clkEn)
			pcLoad <= leaveDelay;
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
			pcLoadValue <= CRTB_RESET_VECTOR;
		else if (clkEn)
			pcLoadValue <= CRTB_RESET_VECTOR;
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
			nmiContext <= 1'b1;
		else if (clkEn)
		begin
			if (rstState_nxt != ST_RUN)
				nmiContext <= 1'b1;
			else if (interruptReturnInstr)
				nmiContext <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
			resetPinPullup <= 1'b1;
		else
			resetPinPullup <= 1'b1;
	end

endmodule : crtb_clock_reset_timebase

/* File: test/crtb_monitor.sv */
/* Checker for the clock, reset and timebase unit.
 Assumes clkEn held high and one clock domain. */
module crtb_monitor
	import crtb_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// Inputs watched
	input wire logic resetPin_n,
	input wire logic porActive,
	input wire logic wdogTimeout,
	input wire logic mainOscReady,
	input wire logic standbyTick,
	input wire logic interruptReturnInstr,
	// Outputs watched
	input wire logic coreTick,
	input wire logic convTick,
	input wire logic displayClkEn,
	input wire logic coreReset,
	input wire logic ioPullupAll,
	input wire logic wdogReinit,
	input wire logic stackClear,
	input wire logic pcLoad,
	input wire logic [11:0] pcLoadValue,
	input wire logic nmiContext
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);
	logic [11:0] quietCnt_r;
	wire srcAny = !resetPin_n || porActive || wdogTimeout;
	sequence srcOn;
		srcAny;
	endsequence
	sequence leaveRst;
		$fell(coreReset);
	endsequence
	// Cycles spent in reset with no source left and the main oscillator ready
	always_ff @(posedge clk_sys)
		quietCnt_r <= (srst || !coreReset || srcAny || !mainOscReady) ? 12'h000 : quietCnt_r + 12'h001;
	AST_CORE_DIV: assert property (coreTick |-> ##13 coreTick)
		else $error("core tick period wrong");
	AST_CONV_DIV: assert property (convTick |-> ##12 convTick)
		else $error("converter tick period wrong");
	AST_RST_ENTER: assert property (srcOn |=> coreReset)
		else $error("reset source ignored");
	AST_RST_DELAY: assert property (leaveRst |-> quietCnt_r inside {[2047:2052]})
		else $error("stabilisation delay wrong");
	AST_LEAVE: assert property (leaveRst |-> stackClear && pcLoad && pcLoadValue == CRTB_RESET_VECTOR)
		else $error("core start missing");
	AST_PC_ONCE: assert property (pcLoad |-> $fell(coreReset))
		else $error("stray program counter load");
	AST_IO_PULL: assert property (ioPullupAll == coreReset && wdogReinit == coreReset)
		else $error("pull-up or watchdog reinit wrong");
	AST_NMI_RST: assert property (coreReset |-> nmiContext)
		else $error("non-maskable context lost in reset");
	AST_NMI_EXIT: assert property ($fell(nmiContext) |-> $past(interruptReturnInstr))
		else $error("context left without return");
	AST_DISPLAY: assert property (displayClkEn |-> $past(standbyTick))
		else $error("display clock without standby tick");
endmodule : crtb_monitor

bind crtb_clock_reset_timebase crtb_monitor i_mon (.clk_sys, .srst, .resetPin_n, .porActive,
	.wdogTimeout, .mainOscReady, .standbyTick, .interruptReturnInstr, .coreTick, .convTick,
	.displayClkEn, .coreReset, .ioPullupAll, .wdogReinit, .stackClear, .pcLoad, .pcLoadValue,
	.nmiContext);

/* File: test/crtb_board.sv */
/* Board model: reset line, power-on detector, both crystals.
 Assumes the bench commands faults just after a rising edge. */
module crtb_board
(
	// Clock and commands
	input wire logic clk_sys,
	input wire logic pinLow,
	input wire logic porOn,
	input wire logic standbyRun,
	// Board signals
	output logic resetPin_n,
	output logic porActive,
	output logic mainOscReady,
	output logic standbyTick
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] tickDiv_r;
	logic [4:0] oscWarm_r = 5'h00;
	// Main crystal needs a start-up time once supply is up
	always @(posedge clk_sys)
		oscWarm_r <= porOn ? 5'h00 : ((oscWarm_r == 5'h1F) ? oscWarm_r : oscWarm_r + 5'h01);
	assign mainOscReady = (oscWarm_r == 5'h1F);
	assign porActive = porOn;
	assign resetPin_n = !pinLow;
	// Crystal stands still while stopped
	always_ff @(posedge clk_sys)
		tickDiv_r <= standbyRun ? tickDiv_r + 2'h1 : 2'h0;
	assign standbyTick = standbyRun && tickDiv_r == 2'h3;
endmodule : crtb_board

/* File: test/crtb_clock_reset_timebase_tb_top.sv */
/* Self-checking bench for the clock, reset and timebase unit.
 Assumes the checker is bound and the board model compiled. */
module crtb_clock_reset_timebase_tb_top
	import crtb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0, srst = 1'b1, wdogTimeout = 1'b0, stopMode = 1'b0;
	logic interruptReturnInstr = 1'b0, regWrite = 1'b0, regRead = 1'b0;
	logic pinLow = 1'b0, porOn = 1'b0, rdPend = 1'b0;
	logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, d;
	logic resetPin_n, porActive, mainOscReady, standbyTick, coreTick, convTick, displayClkEn;
	logic standbyOscRun, coreReset, ioPullupAll, mainOscRestart, wdogReinit, stackClear, pcLoad;
	logic nmiContext, resetPinPullup, timebaseIrq;
	logic [11:0] pcLoadValue;
	logic [7:0] expQ[$];
	int n_errors = 0, checked = 0, cycles = 0, t;
	always #10 clk_sys = ~clk_sys;
	crtb_clock_reset_timebase i_dut (.clk_sys, .srst, .clkEn(1'b1), .resetPin_n, .porActive,
		.wdogTimeout, .mainOscReady, .stopMode, .standbyTick, .interruptReturnInstr, .regAddr,
		.regWrData, .regWrite, .regRead, .regRdData, .coreTick, .convTick, .displayClkEn,
		.standbyOscRun, .coreReset, .ioPullupAll, .mainOscRestart, .wdogReinit, .stackClear,
		.pcLoad, .pcLoadValue, .nmiContext, .resetPinPullup, .timebaseIrq);
	crtb_board i_board (.clk_sys, .pinLow, .porOn, .standbyRun(standbyOscRun), .resetPin_n,
		.porActive, .mainOscReady, .standbyTick);
	task chk(input logic [11:0] seen, input logic [11:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task results;
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : results
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		regAddr <= a;
		regWrData <= v;
		regWrite <= 1'b1;
		@(posedge clk_sys);
		regWrite <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		regAddr <= a;
		regRead <= 1'b1;
		expQ.push_back(e);
		@(posedge clk_sys);
		regRead <= 1'b0;
	endtask : rd
	task waitSig(input logic v);
		t = 0;
		while (((v == 1'b1) ? timebaseIrq : coreReset) !== v && t < 3000)
		begin
			@(negedge clk_sys);
			t++;
		end
	endtask : waitSig
	task irqGap(input logic [7:0] ctl, input int exp);
		int c0;
		wr(8'hDB, ctl);
		repeat (2) @(negedge clk_sys);
		waitSig(1'b1);
		c0 = cycles;
		// Flag cleared before the next period
		wr(8'hDB, ctl);
		repeat (2) @(negedge clk_sys);
		waitSig(1'b1);
		chk(12'(cycles - c0), 12'(exp));
	endtask : irqGap
	always @(posedge clk_sys)
	begin
		if (rdPend)
			chk({4'h0, regRdData}, {4'h0, expQ.pop_front()});
		rdPend <= regRead;
	end
	// Hang guard, well above the expected run
	always @(posedge clk_sys)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			n_errors++;
			results;
		end
	end
	initial
	begin
		void'($urandom(40007));
		repeat (8) @(posedge clk_sys);
		srst <= 1'b0;
		waitSig(1'b0);
		chk(12'(nmiContext), 12'h001);
		chk(12'(resetPinPullup), 12'h001);
		rd(8'hDB, 8'h00);
		d = 8'($urandom);
		wr(8'hDB, {3'b111, d[4:0]});
		wr(8'h10, d);
		rd(8'hDB, 8'hE0);
		rd(8'h10, 8'h00);
		chk(12'(standbyOscRun), 12'h001);
		irqGap(8'hA0, 64);
		irqGap(8'h80, 208);
		// Oscillator off, as before a stop
		wr(8'hDB, 8'h00);
		repeat (250) @(negedge clk_sys);
		chk(12'(timebaseIrq), 12'h000);
		rd(8'hDB, 8'h40);
		@(posedge clk_sys);
		interruptReturnInstr <= 1'b1;
		@(posedge clk_sys);
		interruptReturnInstr <= 1'b0;
		@(negedge clk_sys);
		chk(12'(nmiContext), 12'h000);
		for (int k = 0; k < 3; k++)
		begin
			wr(8'hDB, 8'hA0);
			@(posedge clk_sys);
			pinLow <= (k == 0);
			porOn <= (k == 1);
			wdogTimeout <= (k == 2);
			stopMode <= 1'($urandom);
			repeat ((k == 0) ? 2100 : 1) @(posedge clk_sys);
			{pinLow, porOn, wdogTimeout} <= 3'b000;
			@(negedge clk_sys);
			chk(12'(coreReset), 12'h001);
			chk(12'(mainOscRestart), 12'h001);
			waitSig(1'b0);
			chk(12'(coreReset), 12'h000);
			chk(12'(nmiContext), 12'h001);
			rd(8'hDB, 8'h00);
			rd(8'hDA, {6'h00, (k == 0) ? CAUSE_PIN : ((k == 1) ? CAUSE_POR : CAUSE_WDOG)});
		end
		@(posedge clk_sys);
		results;
	end
endmodule : crtb_clock_reset_timebase_tb_top
